/* File: rtl/adcc_pkg.sv */
// Purpose: Constants and carrier types for the ADC configuration bank
// Assumes: 8-bit register addresses, byte-wide data
// Notes:   Offsets, fields and reset values are named once here
package adcc_pkg;
  localparam logic [7:0] OFS_STATUS    = 8'h00;
  localparam logic [7:0] OFS_GENERAL   = 8'h01;
  localparam logic [7:0] OFS_DATA_FMT  = 8'h02;
  localparam logic [7:0] OFS_AVG       = 8'h03;
  localparam logic [7:0] OFS_OPMODE    = 8'h04;
  localparam logic [7:0] OFS_CHAN_FN   = 8'h05;
  localparam logic [7:0] OFS_DIG_DIR   = 8'h07;
  localparam logic [7:0] RST_DATA_FMT  = 8'h00;
  localparam logic [7:0] RST_AVG       = 8'h00;
  localparam logic [7:0] RST_OPMODE    = 8'h00;
  localparam logic [7:0] RST_CHAN_FN   = 8'h00;
  localparam logic [7:0] RST_DIG_DIR   = 8'h00;
  localparam logic [7:0] MASK_DATA_FMT = 8'hB0;
  localparam logic [7:0] MASK_AVG      = 8'h07;
  localparam int         BIT_DEBUG     = 7;
  localparam int         BIT_TAG_HI    = 5;
  localparam int         BIT_TAG_LO    = 4;
  localparam int         BIT_SEQ_FAULT = 7;
  localparam int         BIT_SCH_HI    = 6;
  localparam int         BIT_SCH_LO    = 5;
  localparam int         BIT_TIMING    = 4;
  localparam int         BIT_RATE_HI   = 3;
  localparam int         BIT_CRC_FLAG  = 1;
  localparam logic [11:0] DEBUG_CODE   = 12'hA5A;
  localparam logic [1:0] TAG_NONE      = 2'h0;
  localparam logic [1:0] TAG_CHAN      = 2'h1;
  localparam logic [1:0] TAG_STATUS    = 2'h2;
  localparam logic [1:0] SCHEME_MANUAL = 2'h0;
  localparam logic [1:0] SCHEME_AUTO   = 2'h1;

  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } adcc_req_t;

  typedef struct packed {
    logic        valid;
    logic [3:0]  chan_id;
    logic [3:0]  flags;
    logic [11:0] code;
  } adcc_sample_t;
endpackage

/* File: rtl/adcc_config_bank.sv */
// Purpose: Data format, averaging, mode and pin configuration registers
// Assumes: Host access decoded upstream into single-cycle requests
// Notes:   Status flag lives outside; it arrives as crc_fault_flag
// Notes on behaviour
// - Debug bit forces fixed code on output samples
// - Tag field appends nothing, channel or flags
// - Reserved bits ignore writes, read zero
// - Averaging code selects 1 to 128 samples
// - Fault bit clear: keep sequencing and pins
// - Fault bit set: pins analog, sequencing paused
// - Flag cleared: resume and restore pins
// - Scheme field selects manual or autonomous
// - Timing bit picks fast or low-power oscillator
// - Rate setting used only in autonomous mode
// - Function bit: analog input or digital pin
// - Direction bit: digital input or output
// - Fault flag blocks writes beyond first two
`timescale 1ns/1ps
module adcc_config_bank (
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire adcc_pkg::adcc_req_t   req,
  input  wire logic                  crc_fault_flag,
  input  wire adcc_pkg::adcc_sample_t sample_in,
  output logic [7:0]                 rdata,
  output logic                       rvalid,
  output logic [15:0]                out_word,
  output logic [1:0]                 out_tag_kind,
  output logic                       out_valid,
  output logic [7:0]                 avg_samples_log2,
  output logic                       autonomous_en,
  output logic                       low_power_osc,
  output logic [3:0]                 rate_setting,
  output logic                       sequencing_run,
  output logic [7:0]                 pin_is_digital,
  output logic [7:0]                 pin_is_output
);
  ////////////////////////////////////////////////////////////////////////
  logic [7:0] data_format_config_reg;
  logic [7:0] averaging_config_reg;
  logic [7:0] operating_mode_config_reg;
  logic [7:0] channel_function_config_reg;
  logic [7:0] digital_direction_config_reg;
  logic       wr_ok;
  logic       paused;
  logic [7:0] rdata_next;
  logic [7:0] fn_eff;
  logic [7:0] dir_eff;

  // Only status and general registers stay writable during a fault
  assign wr_ok = req.wr_en && (!crc_fault_flag ||
                 req.addr == adcc_pkg::OFS_STATUS ||
                 req.addr == adcc_pkg::OFS_GENERAL);
  // Pause lasts exactly as long as the flag; clearing it restores all
  assign paused = crc_fault_flag &&
                  operating_mode_config_reg[adcc_pkg::BIT_SEQ_FAULT];

  always_ff @(posedge core_clk) begin
    if (rst) begin
      data_format_config_reg <= adcc_pkg::RST_DATA_FMT;
    end else if (wr_ok && req.addr == adcc_pkg::OFS_DATA_FMT) begin
      data_format_config_reg <= req.wdata & adcc_pkg::MASK_DATA_FMT;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      averaging_config_reg <= adcc_pkg::RST_AVG;
    end else if (wr_ok && req.addr == adcc_pkg::OFS_AVG) begin
      averaging_config_reg <= req.wdata & adcc_pkg::MASK_AVG;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      operating_mode_config_reg <= adcc_pkg::RST_OPMODE;
    end else if (wr_ok && req.addr == adcc_pkg::OFS_OPMODE) begin
      operating_mode_config_reg <= req.wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      channel_function_config_reg <= adcc_pkg::RST_CHAN_FN;
    end else if (wr_ok && req.addr == adcc_pkg::OFS_CHAN_FN) begin
      channel_function_config_reg <= req.wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      digital_direction_config_reg <= adcc_pkg::RST_DIG_DIR;
    end else if (wr_ok && req.addr == adcc_pkg::OFS_DIG_DIR) begin
      digital_direction_config_reg <= req.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    case (req.addr)
      adcc_pkg::OFS_DATA_FMT: rdata_next = data_format_config_reg;
      adcc_pkg::OFS_AVG:      rdata_next = averaging_config_reg;
      adcc_pkg::OFS_OPMODE:   rdata_next = operating_mode_config_reg;
      adcc_pkg::OFS_CHAN_FN:  rdata_next = channel_function_config_reg;
      adcc_pkg::OFS_DIG_DIR:  rdata_next = digital_direction_config_reg;
      default:                rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata  <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rvalid <= req.rd_en;
      if (req.rd_en) begin
        rdata <= rdata_next;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin roles: fault pause forces analog, direction masked by function
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_pin
      assign fn_eff[g]  = channel_function_config_reg[g] && !paused;
      assign dir_eff[g] = fn_eff[g] &&
                          digital_direction_config_reg[g];
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_is_digital <= 8'h00;
      pin_is_output  <= 8'h00;
      sequencing_run <= 1'b1;
    end else begin
      pin_is_digital <= fn_eff;
      pin_is_output  <= dir_eff;
      sequencing_run <= !paused;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      avg_samples_log2 <= 8'h00;
      autonomous_en    <= 1'b0;
      low_power_osc    <= 1'b0;
      rate_setting     <= 4'h0;
    end else begin
      avg_samples_log2 <= {5'h00, averaging_config_reg[2:0]};
      autonomous_en    <= operating_mode_config_reg[adcc_pkg::BIT_SCH_HI:
                          adcc_pkg::BIT_SCH_LO] == adcc_pkg::SCHEME_AUTO;
      low_power_osc    <= operating_mode_config_reg[adcc_pkg::BIT_TIMING];
      // Rate held at zero in manual mode so nothing downstream free-runs
      if (operating_mode_config_reg[adcc_pkg::BIT_SCH_HI:adcc_pkg::BIT_SCH_LO]
          == adcc_pkg::SCHEME_AUTO) begin
        rate_setting <= operating_mode_config_reg[adcc_pkg::BIT_RATE_HI:0];
      end else begin
        rate_setting <= 4'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output word: code in [15:4], tag nibble in [3:0]
  logic [11:0] code_sel;
  logic [1:0]  tag_sel;
  logic [3:0]  nib_sel;
  assign code_sel = data_format_config_reg[adcc_pkg::BIT_DEBUG] ?
                    adcc_pkg::DEBUG_CODE : sample_in.code;
  assign tag_sel  = data_format_config_reg[adcc_pkg::BIT_TAG_HI:
                                           adcc_pkg::BIT_TAG_LO];
  always_comb begin
    case (tag_sel)
      adcc_pkg::TAG_CHAN:   nib_sel = sample_in.chan_id;
      adcc_pkg::TAG_STATUS: nib_sel = sample_in.flags;
      default:              nib_sel = 4'h0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      out_word     <= 16'h0000;
      out_tag_kind <= 2'h0;
      out_valid    <= 1'b0;
    end else begin
      out_valid <= sample_in.valid;
      if (sample_in.valid) begin
        out_word     <= {code_sel, nib_sel};
        out_tag_kind <= tag_sel;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  property p_blocked;
    @(posedge core_clk) disable iff (rst)
      (req.wr_en && crc_fault_flag && req.addr == adcc_pkg::OFS_CHAN_FN)
      |=> $stable(channel_function_config_reg);
  endproperty
  a_blocked: assert property (p_blocked)
    else $error("Write passed during fault");

  property p_debug;
    @(posedge core_clk) disable iff (rst)
      (sample_in.valid && data_format_config_reg[adcc_pkg::BIT_DEBUG])
      |=> out_valid && out_word[15:4] == adcc_pkg::DEBUG_CODE;
  endproperty
  a_debug: assert property (p_debug)
    else $error("Debug code missing");

  property p_tag_none;
    @(posedge core_clk) disable iff (rst)
      (sample_in.valid && tag_sel == adcc_pkg::TAG_NONE)
      |=> out_word[3:0] == 4'h0;
  endproperty
  a_tag_none: assert property (p_tag_none)
    else $error("Tag appended when off");

  property p_reserved;
    @(posedge core_clk) disable iff (rst)
      data_format_config_reg[6] == 1'b0 &&
      data_format_config_reg[3:0] == 4'h0 &&
      averaging_config_reg[7:3] == 5'h00;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("Reserved bit set");

  property p_pause;
    @(posedge core_clk) disable iff (rst)
      paused |=> pin_is_digital == 8'h00 && !sequencing_run;
  endproperty
  a_pause: assert property (p_pause)
    else $error("Pins not forced analog");

  property p_keep;
    @(posedge core_clk) disable iff (rst)
      (crc_fault_flag && !operating_mode_config_reg[adcc_pkg::BIT_SEQ_FAULT])
      |=> sequencing_run &&
          pin_is_digital == $past(channel_function_config_reg);
  endproperty
  a_keep: assert property (p_keep)
    else $error("Fault disturbed pins");

  property p_restore;
    @(posedge core_clk) disable iff (rst)
      $fell(crc_fault_flag) ##0 !req.wr_en |=>
      sequencing_run && pin_is_digital == channel_function_config_reg;
  endproperty
  a_restore: assert property (p_restore)
    else $error("Config not restored");

  property p_dir;
    @(posedge core_clk) disable iff (rst)
      1'b1 |=> pin_is_output ==
               ($past(digital_direction_config_reg) & pin_is_digital);
  endproperty
  a_dir: assert property (p_dir)
    else $error("Output on analog pin");

  property p_rate;
    @(posedge core_clk) disable iff (rst)
      !autonomous_en |-> ##1 1'b1 ##0 (rate_setting == 4'h0 || autonomous_en);
  endproperty
  a_rate: assert property (p_rate)
    else $error("Rate active in manual");

  c_debug:  cover property (@(posedge core_clk) out_valid &&
                            out_word[15:4] == adcc_pkg::DEBUG_CODE);
  c_pause:  cover property (@(posedge core_clk) paused);
  c_resume: cover property (@(posedge core_clk) $fell(paused));
  c_block:  cover property (@(posedge core_clk) req.wr_en && !wr_ok);
endmodule

/* File: test/adcc_host_status.sv */
// Purpose: Far-side model holding the inbound CRC fault flag
// Assumes: Host writes reach it on the same request bus as the bank
// Notes:   A pulse from the CRC checker stand-in sets the flag
`timescale 1ns/1ps
module adcc_host_status (
  input  wire logic                core_clk,
  input  wire logic                rst,
  input  wire adcc_pkg::adcc_req_t req,
  input  wire logic                crc_err_pulse,
  output logic                     crc_fault_flag
);
  ////////////////////////////////////////////////////////////////////////
  // Set wins over clear so a fresh error is never lost
  always_ff @(posedge core_clk) begin
    if (rst) begin
      crc_fault_flag <= 1'b0;
    end else if (crc_err_pulse) begin
      crc_fault_flag <= 1'b1;
    end else if (req.wr_en && req.addr == adcc_pkg::OFS_STATUS &&
                 req.wdata[adcc_pkg::BIT_CRC_FLAG]) begin
      crc_fault_flag <= 1'b0;
    end
  end
endmodule

/* File: test/tb_adcc_config_bank.sv */
// Purpose: Self-checking bench for the ADC configuration bank
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   wr, rd, smp and fault each leave one idle edge so requests never merge
`timescale 1ns/1ps
module tb_adcc_config_bank;
  logic                   core_clk;
  logic                   rst;
  adcc_pkg::adcc_req_t    req;
  adcc_pkg::adcc_sample_t sample_in;
  logic                   crc_err_pulse;
  logic                   crc_fault_flag;
  logic [7:0]             rdata;
  logic                   rvalid;
  logic [15:0]            out_word;
  logic [1:0]             out_tag_kind;
  logic                   out_valid;
  logic [7:0]             avg_samples_log2;
  logic                   autonomous_en;
  logic                   low_power_osc;
  logic [3:0]             rate_setting;
  logic                   sequencing_run;
  logic [7:0]             pin_is_digital;
  logic [7:0]             pin_is_output;
  int                     err_count;
  int                     comparisons;
  logic [7:0]             ofs_tbl [5] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h07};
  logic [7:0]             msk_tbl [5] = '{8'hB0, 8'h07, 8'hFF, 8'hFF, 8'hFF};
  logic [7:0]             opm_tbl [4] = '{8'h3F, 8'h1F, 8'h45, 8'h2A};

  adcc_config_bank adcc_config_bank_inst (
    .core_clk(core_clk), .rst(rst), .req(req),
    .crc_fault_flag(crc_fault_flag), .sample_in(sample_in),
    .rdata(rdata), .rvalid(rvalid), .out_word(out_word),
    .out_tag_kind(out_tag_kind), .out_valid(out_valid),
    .avg_samples_log2(avg_samples_log2), .autonomous_en(autonomous_en),
    .low_power_osc(low_power_osc), .rate_setting(rate_setting),
    .sequencing_run(sequencing_run), .pin_is_digital(pin_is_digital),
    .pin_is_output(pin_is_output));

  adcc_host_status adcc_host_status_inst (
    .core_clk(core_clk), .rst(rst), .req(req),
    .crc_err_pulse(crc_err_pulse), .crc_fault_flag(crc_fault_flag));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic idle();
    @(posedge core_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req = '{1'b1, 1'b0, a, d};
    @(posedge core_clk);
    #1 req = '0;
    idle();
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    req = '{1'b0, 1'b1, a, 8'h00};
    @(posedge core_clk);
    #1 req = '0;
    chk({8'h01, e}, {7'h00, rvalid, rdata});
    idle();
  endtask

  task automatic smp(input logic [15:0] e, input logic [1:0] k);
    sample_in = '{1'b1, 4'h5, 4'hA, 12'h123};
    @(posedge core_clk);
    #1 sample_in.valid = 1'b0;
    chk(e, out_word);
    chk({13'h0000, 1'b1, k}, {13'h0000, out_valid, out_tag_kind});
    idle();
  endtask

  // Flag sets one edge after the pulse, pins follow one edge later
  task automatic fault();
    crc_err_pulse = 1'b1;
    @(posedge core_clk);
    #1 crc_err_pulse = 1'b0;
    idle();
  endtask

  task automatic conclude();
    if (err_count == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Whole run is about 115 cycles; the 2000-cycle limit means a hang
  initial begin
    #20000;
    err_count++;
    conclude();
  end

  initial begin
    logic [3:0] nib;
    logic       au;
    rst = 1'b1;
    req = '0;
    sample_in = '0;
    crc_err_pulse = 1'b0;
    err_count = 0;
    comparisons = 0;
    repeat (3) @(posedge core_clk);
    #1 rst = 1'b0;
    chk(16'h0001, {15'h0000, sequencing_run});
    for (int i = 0; i < 5; i++) begin
      rd(ofs_tbl[i], 8'h00);
      wr(ofs_tbl[i], 8'hFF);
      rd(ofs_tbl[i], msk_tbl[i]);
    end
    wr(8'h06, 8'hFF);
    rd(8'h06, 8'h00);
    for (int d = 0; d < 2; d++) begin
      for (int t = 0; t < 4; t++) begin
        wr(adcc_pkg::OFS_DATA_FMT, {d[0], 1'b1, t[1:0], 4'hF});
        nib = (t == 1) ? 4'h5 : (t == 2) ? 4'hA : 4'h0;
        smp({d[0] ? 12'hA5A : 12'h123, nib}, t[1:0]);
      end
    end
    for (int a = 0; a < 8; a++) begin
      wr(adcc_pkg::OFS_AVG, {5'h1F, a[2:0]});
      chk({13'h0000, a[2:0]}, {8'h00, avg_samples_log2});
    end
    for (int i = 0; i < 4; i++) begin
      wr(adcc_pkg::OFS_OPMODE, opm_tbl[i]);
      au = (opm_tbl[i][6:5] == 2'b01);
      chk({9'h000, au, opm_tbl[i][4], au ? opm_tbl[i][3:0] : 4'h0, 1'b1},
          {9'h000, autonomous_en, low_power_osc, rate_setting,
           sequencing_run});
    end
    wr(adcc_pkg::OFS_CHAN_FN, 8'hF0);
    wr(adcc_pkg::OFS_DIG_DIR, 8'h3C);
    chk(16'hF030, {pin_is_digital, pin_is_output});
    // Fault with the pause bit clear: pins and sequencing kept
    wr(adcc_pkg::OFS_OPMODE, 8'h20);
    fault();
    chk(16'hF030, {pin_is_digital, pin_is_output});
    chk(16'h0001, {15'h0000, sequencing_run});
    wr(adcc_pkg::OFS_CHAN_FN, 8'h00);
    rd(adcc_pkg::OFS_CHAN_FN, 8'hF0);
    wr(adcc_pkg::OFS_STATUS, 8'h02);
    wr(adcc_pkg::OFS_OPMODE, 8'hA0);
    fault();
    chk(16'h0000, {pin_is_digital, pin_is_output});
    chk(16'h0000, {15'h0000, sequencing_run});
    wr(adcc_pkg::OFS_STATUS, 8'h00);
    chk(16'h0000, {15'h0000, sequencing_run});
    wr(adcc_pkg::OFS_STATUS, 8'h02);
    chk(16'hF030, {pin_is_digital, pin_is_output});
    chk(16'h0001, {15'h0000, sequencing_run});
    conclude();
  end
endmodule
